// ---- core/pqm_monitor.v ----
// Power quality monitor: dip, surge and overcurrent detection, phase order
// counting, temperature refresh flag, no-load clamp, write locks, checksum.
// Assumes all inputs synchronous to clk and one-cycle sample strobes.
//
// Notes on behaviour
// - Detector with window length zero is disabled; zero after reset.
// - Window length counts output-rate samples.
// - Each enabled channel compares sample magnitude with its threshold.
// - Window keeps separate tallies of samples above and below threshold.
// - More below than above at window end sets the dip flag.
// - More above than below at window end sets surge or overcurrent flag.
// - Phase order counts samples from start until next chosen crossing.
// - Writing 10110 to control bits 4:0 starts the phase count.
// - Control bit 5 picks crossing direction; 0 means rising crossing.
// - At crossing: stop, set done flag, store seven-bit count.
// - Temperature refresh every 2240 samples sets the updated flag.
// - Active and reactive sums forced to zero when both below threshold.
// - Apparent sum forced to zero when below threshold, independently.
// - Engine lock field: 0x16 blocks engine writes, 0x09 unblocks.
// - Host lock field: 0x16 ignores host writes, 0x09 restores.
// - Checksum over covered registers recomputed each sample, stored.
// - Checksum computation suspended while disable bit is set.
`include "pqm_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module pqm_monitor #(
    parameter SW  = 24,  // Sample width, two's complement
    parameter LW  = 16,  // Window length width
    parameter PW  = 24,  // Power sum width
    parameter CKW = 24   // Checksum word width
) (
    // Clock and reset
    input  wire                 clk,
    input  wire                 rst,
    // Sample strobe and samples
    input  wire                 sample_stb,
    input  wire [SW-1:0]        volt_ch1,
    input  wire [SW-1:0]        volt_ch2,
    input  wire [SW-1:0]        cur_ch1,
    input  wire [SW-1:0]        cur_ch2,
    // Detector settings
    input  wire [LW-1:0]        dip_window_len_ch1,
    input  wire [LW-1:0]        dip_window_len_ch2,
    input  wire [LW-1:0]        surge_window_len_ch1,
    input  wire [LW-1:0]        surge_window_len_ch2,
    input  wire [LW-1:0]        overcur_window_len_ch1,
    input  wire [LW-1:0]        overcur_window_len_ch2,
    input  wire [SW-1:0]        dip_threshold_ch1,
    input  wire [SW-1:0]        dip_threshold_ch2,
    input  wire [SW-1:0]        surge_threshold_ch1,
    input  wire [SW-1:0]        surge_threshold_ch2,
    input  wire [SW-1:0]        overcur_threshold_ch1,
    input  wire [SW-1:0]        overcur_threshold_ch2,
    // Event flags and host clear, one bit per flag
    input  wire [5:0]           flag_clear,
    output wire                 volt_dip_flag_ch1,
    output wire                 volt_dip_flag_ch2,
    output wire                 volt_surge_flag_ch1,
    output wire                 volt_surge_flag_ch2,
    output wire                 overcurrent_flag_ch1,
    output wire                 overcurrent_flag_ch2,
    // Phase order control
    input  wire                 phase_ctrl_wr,
    input  wire [5:0]           phase_ctrl_wdata,
    input  wire                 volt_zero_rise,
    input  wire                 volt_zero_fall,
    output wire                 phase_order_dir,
    output wire                 phase_order_busy,
    output wire                 phase_order_done,
    output wire [6:0]           phase_order_count,
    // Temperature
    input  wire                 temp_clear,
    output wire                 temp_refresh,
    output wire                 temp_updated_flag,
    // No-load clamp
    input  wire [PW-1:0]        load_min,
    input  wire [PW-1:0]        p_sum_in,
    input  wire [PW-1:0]        q_sum_in,
    input  wire [PW-1:0]        s_sum_in,
    output wire [PW-1:0]        p_sum_out,
    output wire [PW-1:0]        q_sum_out,
    output wire [PW-1:0]        s_sum_out,
    // Write protection
    input  wire                 lock_wr,
    input  wire [4:0]           engine_lock_code,
    input  wire [4:0]           host_lock_code,
    input  wire                 engine_wr_req,
    input  wire                 host_wr_req,
    output wire                 engine_lock_on,
    output wire                 host_lock_on,
    output wire                 engine_wr_ok,
    output wire                 host_wr_ok,
    // Checksum
    input  wire                 checksum_disable,
    input  wire [CKW-1:0]       csum_word,
    input  wire                 csum_first,
    input  wire                 csum_last,
    output wire [CKW-1:0]       config_checksum_result
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Magnitude of a signed sample, saturating the most negative value
    function [SW-1:0] pqm_abs;
        input [SW-1:0] v;
        begin
            if (!v[SW-1])
                pqm_abs = v;
            else if (v == {1'b1, {(SW-1){1'b0}}})
                pqm_abs = {1'b0, {(SW-1){1'b1}}};
            else
                pqm_abs = (~v) + {{(SW-1){1'b0}}, 1'b1};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Window detectors: index 0,1 dip; 2,3 surge; 4,5 overcurrent

    wire [SW-1:0] smp [0:5];
    wire [SW-1:0] thr [0:5];
    wire [LW-1:0] wlen [0:5];
    assign smp[0] = volt_ch1;
    assign smp[1] = volt_ch2;
    assign smp[2] = volt_ch1;
    assign smp[3] = volt_ch2;
    assign smp[4] = cur_ch1;
    assign smp[5] = cur_ch2;
    assign thr[0] = dip_threshold_ch1;
    assign thr[1] = dip_threshold_ch2;
    assign thr[2] = surge_threshold_ch1;
    assign thr[3] = surge_threshold_ch2;
    assign thr[4] = overcur_threshold_ch1;
    assign thr[5] = overcur_threshold_ch2;
    assign wlen[0] = dip_window_len_ch1;
    assign wlen[1] = dip_window_len_ch2;
    assign wlen[2] = surge_window_len_ch1;
    assign wlen[3] = surge_window_len_ch2;
    assign wlen[4] = overcur_window_len_ch1;
    assign wlen[5] = overcur_window_len_ch2;

    reg [LW-1:0] pos_ff [0:5];
    reg [LW-1:0] above_ff [0:5];
    reg [LW-1:0] below_ff [0:5];
    reg [5:0]    flag_ff;

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : det
            wire          en     = (wlen[g] != `PQM_WIN_LEN_RST);
            wire          is_hi  = (pqm_abs(smp[g]) > thr[g]);
            wire          is_lo  = (pqm_abs(smp[g]) < thr[g]);
            wire          lastw  = (pos_ff[g] + {{(LW-1){1'b0}}, 1'b1}) >= wlen[g];
            wire [LW-1:0] nxt_ab = above_ff[g] + {{(LW-1){1'b0}}, is_hi};
            wire [LW-1:0] nxt_be = below_ff[g] + {{(LW-1){1'b0}}, is_lo};
            // Dip indices look at the below tally, the others at above
            wire          hit    = (g < 2) ? (nxt_be > nxt_ab) : (nxt_ab > nxt_be);
            wire          set_f  = sample_stb & en & lastw & hit;

            // Window position and tallies, restart each window
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    pos_ff[g]   <= {LW{1'b0}};
                    above_ff[g] <= {LW{1'b0}};
                    below_ff[g] <= {LW{1'b0}};
                end else if (!en) begin
                    pos_ff[g]   <= {LW{1'b0}};
                    above_ff[g] <= {LW{1'b0}};
                    below_ff[g] <= {LW{1'b0}};
                end else if (sample_stb) begin
                    if (lastw) begin
                        pos_ff[g]   <= {LW{1'b0}};
                        above_ff[g] <= {LW{1'b0}};
                        below_ff[g] <= {LW{1'b0}};
                    end else begin
                        pos_ff[g]   <= pos_ff[g] + {{(LW-1){1'b0}}, 1'b1};
                        above_ff[g] <= nxt_ab;
                        below_ff[g] <= nxt_be;
                    end
                end
            end

            // Sticky flag; a set in the clear cycle wins
            always @(posedge clk or posedge rst) begin
                if (rst)
                    flag_ff[g] <= 1'b0;
                else if (set_f)
                    flag_ff[g] <= 1'b1;
                else if (flag_clear[g])
                    flag_ff[g] <= 1'b0;
            end
        end
    endgenerate

    assign volt_dip_flag_ch1    = flag_ff[0];
    assign volt_dip_flag_ch2    = flag_ff[1];
    assign volt_surge_flag_ch1  = flag_ff[2];
    assign volt_surge_flag_ch2  = flag_ff[3];
    assign overcurrent_flag_ch1 = flag_ff[4];
    assign overcurrent_flag_ch2 = flag_ff[5];

    ////////////////////////////////////////////////////////////////////////
    // Phase order counter

    reg       dir_ff;
    reg       busy_ff;
    reg       done_ff;
    reg [6:0] pcnt_ff;
    reg [6:0] run_ff;

    wire start   = phase_ctrl_wr &
                   (phase_ctrl_wdata[`PQM_PHASE_CODE_MSB:0] == `PQM_PHASE_START_CODE);
    wire crossing = dir_ff ? volt_zero_fall : volt_zero_rise;

    // Count saturates at the field maximum rather than wrapping
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dir_ff  <= 1'b0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            pcnt_ff <= 7'h00;
            run_ff  <= 7'h00;
        end else if (phase_ctrl_wr) begin
            dir_ff <= phase_ctrl_wdata[`PQM_PHASE_DIR_BIT];
            if (start) begin
                busy_ff <= 1'b1;
                done_ff <= 1'b0;
                run_ff  <= 7'h00;
            end
        end else if (busy_ff) begin
            if (crossing) begin
                busy_ff <= 1'b0;
                done_ff <= 1'b1;
                pcnt_ff <= run_ff;
            end else if (sample_stb && run_ff != `PQM_PHASE_CNT_MAX) begin
                run_ff <= run_ff + 7'h01;
            end
        end
    end

    assign phase_order_dir   = dir_ff;
    assign phase_order_busy  = busy_ff;
    assign phase_order_done  = done_ff;
    assign phase_order_count = pcnt_ff;

    ////////////////////////////////////////////////////////////////////////
    // Temperature refresh timer

    reg [11:0] tcnt_ff;
    reg        tup_ff;
    reg        tref_ff;
    wire       twrap = sample_stb && (tcnt_ff == `PQM_TEMP_PERIOD - 12'd1);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tcnt_ff <= 12'd0;
            tup_ff  <= 1'b0;
            tref_ff <= 1'b0;
        end else begin
            tref_ff <= twrap;
            if (sample_stb)
                tcnt_ff <= twrap ? 12'd0 : tcnt_ff + 12'd1;
            if (twrap)
                tup_ff <= 1'b1;
            else if (temp_clear)
                tup_ff <= 1'b0;
        end
    end

    assign temp_refresh      = tref_ff;
    assign temp_updated_flag = tup_ff;

    ////////////////////////////////////////////////////////////////////////
    // No-load clamp, registered outputs

    reg [PW-1:0] p_ff;
    reg [PW-1:0] q_ff;
    reg [PW-1:0] s_ff;
    wire [PW-1:0] p_mag = p_sum_in[PW-1] ? (~p_sum_in) + {{(PW-1){1'b0}}, 1'b1} : p_sum_in;
    wire [PW-1:0] q_mag = q_sum_in[PW-1] ? (~q_sum_in) + {{(PW-1){1'b0}}, 1'b1} : q_sum_in;
    wire          pq_low = (p_mag < load_min) && (q_mag < load_min);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            p_ff <= {PW{1'b0}};
            q_ff <= {PW{1'b0}};
            s_ff <= {PW{1'b0}};
        end else if (sample_stb) begin
            p_ff <= pq_low ? {PW{1'b0}} : p_sum_in;
            q_ff <= pq_low ? {PW{1'b0}} : q_sum_in;
            s_ff <= (s_sum_in < load_min) ? {PW{1'b0}} : s_sum_in;
        end
    end

    assign p_sum_out = p_ff;
    assign q_sum_out = q_ff;
    assign s_sum_out = s_ff;

    ////////////////////////////////////////////////////////////////////////
    // Write protection

    reg elock_ff;
    reg hlock_ff;

    // Unknown codes fall through and keep the state
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            elock_ff <= 1'b0;
            hlock_ff <= 1'b0;
        end else if (lock_wr) begin
            if (engine_lock_code == `PQM_LOCK_ON_CODE)
                elock_ff <= 1'b1;
            else if (engine_lock_code == `PQM_LOCK_OFF_CODE)
                elock_ff <= 1'b0;
            if (host_lock_code == `PQM_LOCK_ON_CODE)
                hlock_ff <= 1'b1;
            else if (host_lock_code == `PQM_LOCK_OFF_CODE)
                hlock_ff <= 1'b0;
        end
    end

    assign engine_lock_on = elock_ff;
    assign host_lock_on   = hlock_ff;
    assign engine_wr_ok   = engine_wr_req & ~elock_ff;
    assign host_wr_ok     = host_wr_req & ~hlock_ff;

    ////////////////////////////////////////////////////////////////////////
    // Register checksum: words streamed in after each sample

    reg [CKW-1:0] acc_ff;
    reg [CKW-1:0] csum_ff;
    reg           scan_ff;

    // Sum of words; the scan is armed on every sample strobe while checksum_disable is low
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_ff  <= {CKW{1'b0}};
            csum_ff <= {CKW{1'b0}};
            scan_ff <= 1'b0;
        end else if (checksum_disable) begin
            scan_ff <= 1'b0;
        end else begin
            if (sample_stb)
                scan_ff <= 1'b1;
            if (scan_ff && csum_first && csum_last) begin
                csum_ff <= csum_word;
                scan_ff <= sample_stb;
            end else if (scan_ff && csum_first) begin
                acc_ff <= csum_word;
            end else if (scan_ff && csum_last) begin
                csum_ff <= acc_ff + csum_word;
                scan_ff <= sample_stb;
            end else if (scan_ff) begin
                acc_ff <= acc_ff + csum_word;
            end
        end
    end

    assign config_checksum_result = csum_ff;

endmodule

`default_nettype wire

// ---- core/pqm_consts.vh ----
// Constants for the power quality monitor: control codes, field positions,
// reset values and timing counts. Definitions only.
`ifndef PQM_CONSTS_VH
`define PQM_CONSTS_VH

// Phase order start code and field layout
`define PQM_PHASE_START_CODE 5'h16
`define PQM_PHASE_CODE_MSB   4
`define PQM_PHASE_DIR_BIT    5
`define PQM_PHASE_CNT_W      7
`define PQM_PHASE_CNT_MAX    7'h7f

// Write protection codes
`define PQM_LOCK_ON_CODE     5'h16
`define PQM_LOCK_OFF_CODE    5'h09

// Temperature refresh period in samples
`define PQM_TEMP_PERIOD      12'd2240

// Reset values
`define PQM_WIN_LEN_RST      16'h0000

`endif

// ---- sim/pqm_host_model.sv ----
// Sample source on the far side of the monitor: emits output-rate strobes.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module pqm_host_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Burst request
    input  wire logic        req,
    input  wire logic [11:0] cnt,
    // Strobe out and status
    output var  logic        sample_stb,
    output logic             idle
);
    ////////////////////////////////////////////////////////////////////////
    logic [12:0] left_ff;

    // Two cycles per sample so that no two strobes ever touch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            left_ff    <= 13'h0000;
            sample_stb <= 1'b0;
        end else begin
            sample_stb <= 1'b0;
            if (req) begin
                left_ff <= {cnt, 1'b0};
            end else if (left_ff != 13'h0000) begin
                left_ff    <= left_ff - 13'h0001;
                sample_stb <= left_ff[0];
            end
        end
    end

    // Idle already in the cycle that the last strobe is driven out
    assign idle = (left_ff == 13'h0000) && !req;
endmodule
`default_nettype wire

// ---- sim/pqm_monitor_properties.sv ----
// Checker for the power quality monitor, bound to its top module.
// Assumes one clock domain and an active-high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module pqm_monitor_chk (
    // Clock, reset, strobe
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        sample_stb,
    // Detector and temperature
    input wire logic [15:0] dip_window_len_ch1,
    input wire logic        volt_dip_flag_ch1,
    input wire logic        temp_refresh,
    input wire logic        temp_updated_flag,
    // Phase order
    input wire logic        phase_ctrl_wr,
    input wire logic [5:0]  phase_ctrl_wdata,
    input wire logic        volt_zero_rise,
    input wire logic        volt_zero_fall,
    input wire logic        phase_order_dir,
    input wire logic        phase_order_busy,
    input wire logic        phase_order_done,
    // Clamp
    input wire logic [23:0] load_min,
    input wire logic [23:0] p_sum_in,
    input wire logic [23:0] q_sum_in,
    input wire logic [23:0] s_sum_in,
    input wire logic [23:0] p_sum_out,
    input wire logic [23:0] q_sum_out,
    input wire logic [23:0] s_sum_out,
    // Locks and checksum
    input wire logic        lock_wr,
    input wire logic [4:0]  engine_lock_code,
    input wire logic [4:0]  host_lock_code,
    input wire logic        engine_lock_on,
    input wire logic        host_lock_on,
    input wire logic        checksum_disable,
    input wire logic [23:0] config_checksum_result
);
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_dip_needs_len: assert property ($rose(volt_dip_flag_ch1) |->
        $past(dip_window_len_ch1) != 16'h0000) else $error("dip flag with window off");
    a_phase_start: assert property (phase_ctrl_wr && phase_ctrl_wdata[4:0] == 5'h16
        |=> phase_order_busy && !phase_order_done) else $error("phase start missed");
    a_phase_dir: assert property (phase_ctrl_wr |=>
        phase_order_dir == $past(phase_ctrl_wdata[5])) else $error("direction not taken");
    a_phase_stop: assert property (phase_order_busy && !phase_ctrl_wr &&
        (phase_order_dir ? volt_zero_fall : volt_zero_rise)
        |=> phase_order_done && !phase_order_busy) else $error("phase did not stop");
    a_temp_flag: assert property (temp_refresh |-> temp_updated_flag)
        else $error("refresh without flag");
    a_clamp_pq: assert property (sample_stb &&
        (p_sum_in[23] ? 24'h0 - p_sum_in : p_sum_in) < load_min &&
        (q_sum_in[23] ? 24'h0 - q_sum_in : q_sum_in) < load_min
        |=> p_sum_out == 24'h0 && q_sum_out == 24'h0)
        else $error("p q not clamped");
    a_clamp_s: assert property (sample_stb && s_sum_in < load_min
        |=> s_sum_out == 24'h0) else $error("s not clamped");
    a_engine_lock: assert property (lock_wr && engine_lock_code == 5'h16
        |=> engine_lock_on ##1 engine_lock_on || lock_wr) else $error("engine lock");
    a_host_unlock: assert property (lock_wr && host_lock_code == 5'h09
        |=> !host_lock_on) else $error("host unlock missed");
    a_lock_keep: assert property (lock_wr && engine_lock_code != 5'h16 &&
        engine_lock_code != 5'h09 |=> $stable(engine_lock_on)) else $error("lock moved");
    a_csum_held: assert property (checksum_disable && $past(checksum_disable)
        |=> $stable(config_checksum_result)) else $error("checksum moved");

    // Main scenarios reached
    c_dip: cover property ($rose(volt_dip_flag_ch1));
    c_phase: cover property ($rose(phase_order_done));
    c_temp: cover property (temp_refresh);
endmodule

bind pqm_monitor pqm_monitor_chk i_chk (.*);
`default_nettype wire

// ---- sim/pqm_monitor_tb.sv ----
// Self-checking bench for the power quality monitor, one task per scenario.
// Assumes the monitor core, sample source model and checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module pqm_monitor_tb;
    logic        clk, rst, sample_stb, phase_ctrl_wr, volt_zero_rise, volt_zero_fall;
    logic        temp_clear, temp_refresh, temp_updated_flag, lock_wr, req, idle;
    logic        engine_wr_req, host_wr_req, engine_lock_on, host_lock_on;
    logic        engine_wr_ok, host_wr_ok, checksum_disable, csum_first, csum_last;
    logic        volt_dip_flag_ch1, volt_dip_flag_ch2, volt_surge_flag_ch1;
    logic        volt_surge_flag_ch2, overcurrent_flag_ch1, overcurrent_flag_ch2;
    logic        phase_order_dir, phase_order_busy, phase_order_done;
    logic [4:0]  engine_lock_code, host_lock_code;
    logic [5:0]  flag_clear, phase_ctrl_wdata;
    logic [6:0]  phase_order_count;
    logic [11:0] cnt;
    logic [15:0] dip_window_len_ch1, dip_window_len_ch2, surge_window_len_ch1;
    logic [15:0] surge_window_len_ch2, overcur_window_len_ch1, overcur_window_len_ch2;
    logic [23:0] volt_ch1, volt_ch2, cur_ch1, cur_ch2, load_min, p_sum_in, q_sum_in;
    logic [23:0] s_sum_in, p_sum_out, q_sum_out, s_sum_out, csum_word;
    logic [23:0] dip_threshold_ch1, dip_threshold_ch2, surge_threshold_ch1;
    logic [23:0] surge_threshold_ch2, overcur_threshold_ch1, overcur_threshold_ch2;
    logic [23:0] config_checksum_result;
    int          mismatches, compares;
    wire  [5:0]  flg = {overcurrent_flag_ch2, overcurrent_flag_ch1, volt_surge_flag_ch2,
                        volt_surge_flag_ch1, volt_dip_flag_ch2, volt_dip_flag_ch1};

    pqm_monitor i_dut (.*);
    pqm_host_model i_host (.*);

    ////////////////////////////////////////////////////////////////////////
    // Clock, 40 ns period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Sample after the edge so registered outputs have landed
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic stbs(input int n);
        @(posedge clk) req <= 1'b1;
        cnt <= n[11:0];
        @(posedge clk) req <= 1'b0;
        for (int i = 0; i < 6000 && idle !== 1'b1; i++) tick(1);
        if (idle !== 1'b1) chk("burst idle", 24'h1, idle);
        tick(1);
    endtask
    task automatic feed(input logic [23:0] v);
        @(posedge clk) {volt_ch1, volt_ch2, cur_ch1, cur_ch2} <= {4{v}};
        stbs(1);
    endtask
    task automatic set_len(input logic [15:0] d, input logic [15:0] s, input logic [15:0] o);
        @(posedge clk) {dip_window_len_ch1, dip_window_len_ch2} <= {2{d}};
        {surge_window_len_ch1, surge_window_len_ch2} <= {2{s}};
        {overcur_window_len_ch1, overcur_window_len_ch2} <= {2{o}};
    endtask
    task automatic clr;
        @(posedge clk) flag_clear <= 6'h3f;
        @(posedge clk) flag_clear <= 6'h00;
        tick(1);
        chk("flags cleared", 24'h0, flg);
    endtask
    task automatic pwr(input logic [5:0] d);
        @(posedge clk) phase_ctrl_wr <= 1'b1;
        phase_ctrl_wdata <= d;
        @(posedge clk) phase_ctrl_wr <= 1'b0;
        tick(1);
    endtask
    task automatic zc(input logic f);
        @(posedge clk) volt_zero_rise <= ~f;
        volt_zero_fall <= f;
        @(posedge clk) volt_zero_rise <= 1'b0;
        volt_zero_fall <= 1'b0;
        tick(1);
    endtask
    task automatic lk(input logic [4:0] e, input logic [4:0] h, input logic [1:0] ok);
        @(posedge clk) lock_wr <= 1'b1;
        {engine_lock_code, host_lock_code} <= {e, h};
        @(posedge clk) lock_wr <= 1'b0;
        tick(1);
        chk("write ok", {22'h0, ok}, {engine_wr_ok, host_wr_ok});
        chk("lock state", {22'h0, ~ok}, {engine_lock_on, host_lock_on});
    endtask
    task automatic cw(input logic [23:0] w, input logic f, input logic l);
        @(posedge clk) csum_word <= w;
        {csum_first, csum_last} <= {f, l};
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Temperature goes first: its period counts every strobe since reset
    task automatic t_temp;
        chk("reset flags", 24'h0, {flg, engine_lock_on, phase_order_done});
        stbs(2239);
        chk("temp early", 24'h0, temp_updated_flag);
        stbs(1);
        chk("temp set", 24'h1, temp_updated_flag);
        @(posedge clk) temp_clear <= 1'b1;
        @(posedge clk) temp_clear <= 1'b0;
        tick(1);
        chk("temp clear", 24'h0, temp_updated_flag);
        $display("temperature test done");
    endtask
    // Negative samples exercise the magnitude; surge off while dip runs
    task automatic t_detect;
        set_len(16'd4, 16'd0, 16'd0);
        feed(24'hffffce);
        feed(24'h00001e);
        feed(24'hffff38);
        feed(24'h00000a);
        chk("dip flags", 24'h03, flg);
        clr();
        set_len(16'd0, 16'd4, 16'd4);
        feed(24'hffff38);
        feed(24'h000096);
        feed(24'h000032);
        feed(24'hfffed4);
        chk("surge flags", 24'h3c, flg);
        clr();
        feed(24'h0000c8);
        feed(24'h00000a);
        feed(24'hffff38);
        feed(24'h000005);
        chk("tied window", 24'h0, flg);
        $display("detector test done");
    endtask
    task automatic t_phase;
        pwr(6'h16);
        chk("busy", 24'h1, phase_order_busy);
        stbs(3);
        zc(1'b0);
        chk("count", 24'h3, {phase_order_done, phase_order_count} ^ 24'h80);
        pwr(6'h36);
        chk("direction", 24'h1, phase_order_dir);
        stbs(2);
        zc(1'b0);
        chk("wrong edge", 24'h1, phase_order_busy);
        zc(1'b1);
        chk("count fall", 24'h2, {phase_order_done, phase_order_count} ^ 24'h80);
        pwr(6'h15);
        chk("bad code", 24'h0, phase_order_busy);
        $display("phase test done");
    endtask
    task automatic t_clamp;
        @(posedge clk) {load_min, p_sum_in, q_sum_in} <= {24'd10, 24'd20, 24'hfffffd};
        s_sum_in <= 24'd50;
        stbs(1);
        chk("p pass", 24'd20, p_sum_out);
        chk("q pass", 24'hfffffd, q_sum_out);
        chk("s pass", 24'd50, s_sum_out);
        @(posedge clk) {p_sum_in, s_sum_in} <= {24'd5, 24'd5};
        stbs(1);
        chk("clamped", 24'h0, p_sum_out | q_sum_out | s_sum_out);
        $display("clamp test done");
    endtask
    task automatic t_lock;
        lk(5'h16, 5'h16, 2'b00);
        lk(5'h03, 5'h09, 2'b01);
        lk(5'h09, 5'h1f, 2'b11);
        $display("lock test done");
    endtask
    task automatic t_csum;
        stbs(1);
        cw(24'h1, 1'b1, 1'b0);
        cw(24'h2, 1'b0, 1'b0);
        cw(24'h3, 1'b0, 1'b1);
        cw(24'h0, 1'b0, 1'b0);
        tick(2);
        chk("checksum", 24'h6, config_checksum_result);
        @(posedge clk) checksum_disable <= 1'b1;
        stbs(1);
        cw(24'h5, 1'b1, 1'b0);
        cw(24'h5, 1'b0, 1'b1);
        cw(24'h0, 1'b0, 1'b0);
        tick(2);
        chk("checksum held", 24'h6, config_checksum_result);
        $display("checksum test done");
    endtask

    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog, about twice the expected run
    initial begin
        #400000;
        mismatches++;
        wrap_up();
    end

    initial begin
        {rst, req, cnt, flag_clear, phase_ctrl_wdata, csum_word} = {1'b1, 49'h0};
        {phase_ctrl_wr, volt_zero_rise, volt_zero_fall, temp_clear, lock_wr} = 5'h00;
        {engine_wr_req, host_wr_req, checksum_disable, csum_first, csum_last} = 5'h18;
        {engine_lock_code, host_lock_code, load_min, p_sum_in, q_sum_in, s_sum_in} = '0;
        {volt_ch1, volt_ch2, cur_ch1, cur_ch2} = '0;
        {dip_window_len_ch1, dip_window_len_ch2, surge_window_len_ch1} = '0;
        {surge_window_len_ch2, overcur_window_len_ch1, overcur_window_len_ch2} = '0;
        {dip_threshold_ch1, dip_threshold_ch2, surge_threshold_ch1} = {3{24'd100}};
        {surge_threshold_ch2, overcur_threshold_ch1, overcur_threshold_ch2} = {3{24'd100}};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        t_temp();
        t_detect();
        t_phase();
        t_clamp();
        t_lock();
        t_csum();
        wrap_up();
    end
endmodule
`default_nettype wire
